// ---- src/bci_pkg.sv ----
package bci_pkg;

  // Clock rate and oscillator settling times
  localparam int unsigned CLK_FREQ_KHZ  = 250000;
  localparam int unsigned T_STAB_CER_MS = 4;
  localparam int unsigned T_STAB_XTL_MS = 30;
  // Longest times, rounded down to whole cycles
  localparam int unsigned STAB_CER_CYC  = T_STAB_CER_MS * CLK_FREQ_KHZ;
  localparam int unsigned STAB_XTL_CYC  = T_STAB_XTL_MS * CLK_FREQ_KHZ;
  localparam int unsigned STAB_W        = 23;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_INSTR  = 8'h04;
  localparam logic [7:0] ADDR_PC     = 8'h08;
  localparam logic [7:0] ADDR_REGS   = 8'h0c;
  localparam logic [7:0] ADDR_PSW    = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // Control fields
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_XTAL  = 1;
  localparam int unsigned CTRL_PCC   = 2;
  // Instruction fields
  localparam int unsigned INS_OP     = 0;
  localparam int unsigned INS_BIT    = 8;
  localparam int unsigned INS_DISP   = 16;
  localparam int unsigned INS_SFR    = 24;
  // Register file fields
  localparam int unsigned RG_A       = 0;
  localparam int unsigned RG_B       = 8;
  localparam int unsigned RG_C       = 16;
  localparam int unsigned RG_MEM     = 24;
  // Processor state word bits
  localparam int unsigned PSW_CY     = 0;
  localparam int unsigned PSW_Z      = 6;
  localparam int unsigned PSW_IE     = 7;

  // Reset values
  localparam logic [3:0]  CTRL_RST  = 4'h0;
  localparam logic [31:0] INSTR_RST = 32'h0000_0000;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [31:0] REGS_RST  = 32'h0000_0000;
  localparam logic [7:0]  PSW_RST   = 8'h00;

  // Operation codes
  typedef enum logic [4:0] {
    OP_NOP      = 5'h00, OP_BC       = 5'h01, OP_BNC      = 5'h02,
    OP_BZ       = 5'h03, OP_BNZ      = 5'h04, OP_BT_SADDR = 5'h05,
    OP_BT_SFR   = 5'h06, OP_BT_ACC   = 5'h07, OP_BT_PSW   = 5'h08,
    OP_BF_SADDR = 5'h09, OP_BF_SFR   = 5'h0a, OP_BF_ACC   = 5'h0b,
    OP_BF_PSW   = 5'h0c, OP_DECREMENT_AND_LOOP_BRANCH_B   = 5'h0d, OP_DECREMENT_AND_LOOP_BRANCH_C   = 5'h0e,
    OP_DECREMENT_AND_LOOP_BRANCH_MEM = 5'h0f, OP_EI       = 5'h10, OP_DI       = 5'h11,
    OP_HALT     = 5'h12, OP_STOP     = 5'h13
  } bci_op_e;

  // Core states
  typedef enum logic [2:0] {
    ST_STAB = 3'b000,
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_HALT = 3'b011,
    ST_STOP = 3'b100
  } bci_state_e;

endpackage : bci_pkg

// ---- src/bci_core.sv ----
`timescale 1ns/1ns
// Summary of operation
// - Carry and zero branches are 2 bytes, 6 clocks, PC+2+offset when the flag matches.
// - Bit-set branch on a short-direct bit is 4 bytes, 10 clocks, PC+4+offset if bit is 1.
// - Bit-set branch on an accumulator bit is 3 bytes, 8 clocks, PC+3+offset if bit is 1.
// - Bit-set branch on a state-word or special register bit is 4 bytes, 10 clocks.
// - Bit-clear branches match the bit-set forms but branch when the bit is 0.
// - Loop branch on B or C is 2 bytes, 6 clocks, decrements then branches if nonzero.
// - Loop branch on a memory byte is 3 bytes, 8 clocks, decrements then branches if nonzero.
// - Interrupt-allow is 3 bytes, 6 clocks and sets the interrupt accept flag.
// - Interrupt-block is 3 bytes, 6 clocks and clears the interrupt accept flag.
// - After reset the core always waits 4 ms (ceramic); after stop release 4 ms (ceramic) or 30 ms (crystal).
// - Instruction clocks are counted in cycles of the selected CPU clock.
module bci_core #(
  parameter int unsigned CER_CYCLES = bci_pkg::STAB_CER_CYC,
  parameter int unsigned XTL_CYCLES = bci_pkg::STAB_XTL_CYC
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Standby release pin
  input  wire logic        wake_in,
  // Core status
  output logic             int_accept,
  output logic             instr_done,
  output logic             cpu_run
);
  import bci_pkg::*;

  // Byte length of each operation
  function automatic logic [2:0] op_len(input logic [4:0] op);
    unique case (op)
      OP_BC, OP_BNC, OP_BZ, OP_BNZ, OP_DECREMENT_AND_LOOP_BRANCH_B, OP_DECREMENT_AND_LOOP_BRANCH_C: op_len = 3'h2;
      OP_BT_SADDR, OP_BT_SFR, OP_BT_PSW,
      OP_BF_SADDR, OP_BF_SFR, OP_BF_PSW:                  op_len = 3'h4;
      OP_BT_ACC, OP_BF_ACC, OP_DECREMENT_AND_LOOP_BRANCH_MEM, OP_EI, OP_DI:    op_len = 3'h3;
      default:                                            op_len = 3'h1;
    endcase
  endfunction : op_len
  // CPU clocks of each operation
  function automatic logic [3:0] op_clk(input logic [4:0] op);
    unique case (op)
      OP_BC, OP_BNC, OP_BZ, OP_BNZ, OP_DECREMENT_AND_LOOP_BRANCH_B, OP_DECREMENT_AND_LOOP_BRANCH_C,
      OP_EI, OP_DI:                                       op_clk = 4'h6;
      OP_BT_SADDR, OP_BT_SFR, OP_BT_PSW,
      OP_BF_SADDR, OP_BF_SFR, OP_BF_PSW:                  op_clk = 4'ha;
      OP_BT_ACC, OP_BF_ACC, OP_DECREMENT_AND_LOOP_BRANCH_MEM:                  op_clk = 4'h8;
      default:                                            op_clk = 4'h2;
    endcase
  endfunction : op_clk

  // State
  bci_state_e        state_q, state_d;
  logic [3:0]        ctrl_q;
  logic [31:0]       instr_q;
  logic [15:0]       pc_q, pc_d;
  logic [31:0]       regs_q, regs_d;
  logic [7:0]        psw_q, psw_d;
  logic [4:0]        op_q;
  logic              taken_q;
  logic [7:0]        dec_q;
  logic [3:0]        cnt_q;
  logic [2:0]        div_q;
  logic [STAB_W-1:0] stab_q, stab_d;
  logic              w1_q, w2_q, w3_q, wake_q;
  logic [31:0]       prdata_q;
  logic              pready_q, pslverr_q, done_q, run_q;

  // APB decode
  wire setup_w = psel & ~penable & ~pready_q;
  wire acc_w   = psel & penable & pready_q;
  wire wr_w    = acc_w & pwrite;
  wire hit_ctl = (paddr == ADDR_CTRL);
  wire hit_ins = (paddr == ADDR_INSTR);
  wire hit_pc  = (paddr == ADDR_PC);
  wire hit_rg  = (paddr == ADDR_REGS);
  wire hit_psw = (paddr == ADDR_PSW);
  wire hit_st  = (paddr == ADDR_STATUS);
  wire mapped  = hit_ctl | hit_ins | hit_pc | hit_rg | hit_psw | hit_st;
  // Operand registers are locked while an instruction runs
  wire busy_w  = (state_q == ST_EXEC);
  wire wr_ok   = wr_w & ~busy_w;
  // Read mux
  wire [31:0] status_w = {27'h0, state_q == ST_STAB, state_q == ST_STOP,
                          state_q == ST_HALT, taken_q, busy_w};
  wire [31:0] rd_w = hit_ctl ? {28'h0, ctrl_q} :
                     hit_ins ? instr_q :
                     hit_pc  ? {16'h0, pc_q} :
                     hit_rg  ? regs_q :
                     hit_psw ? {24'h0, psw_q} :
                     hit_st  ? status_w : 32'h0;

  // Instruction fields
  wire [4:0] op_w   = instr_q[INS_OP +: 5];
  wire [2:0] bit_w  = instr_q[INS_BIT +: 3];
  wire [7:0] disp_w = instr_q[INS_DISP +: 8];
  wire [7:0] sfr_w  = instr_q[INS_SFR +: 8];
  wire [7:0] a_w    = regs_q[RG_A +: 8];
  wire [7:0] b_w    = regs_q[RG_B +: 8];
  wire [7:0] c_w    = regs_q[RG_C +: 8];
  wire [7:0] mem_w  = regs_q[RG_MEM +: 8];

  // Start request, taken only when the core idles
  wire go_w = ce & wr_ok & hit_ctl & pwdata[CTRL_START] & (state_q == ST_IDLE);
  // Selected CPU clock: one tick every 2^sel bus clocks, phase set at start
  wire [1:0] pcc_w   = ctrl_q[CTRL_PCC +: 2];
  wire [2:0] mask_w  = (pcc_w == 2'h0) ? 3'h0 : (pcc_w == 2'h1) ? 3'h1 :
                       (pcc_w == 2'h2) ? 3'h3 : 3'h7;
  wire       tick_w  = ((div_q & mask_w) == 3'h0);
  wire       fin_w   = busy_w & tick_w & (cnt_q == op_clk(op_q) - 4'h1);

  // Tested bit and loop result, captured at start
  wire       bit_a   = a_w[bit_w];
  wire       bit_m   = mem_w[bit_w];
  wire       bit_s   = sfr_w[bit_w];
  wire       bit_p   = psw_q[bit_w];
  wire [7:0] dec_w   = (op_w == OP_DECREMENT_AND_LOOP_BRANCH_B) ? b_w - 8'h1 :
                       (op_w == OP_DECREMENT_AND_LOOP_BRANCH_C) ? c_w - 8'h1 : mem_w - 8'h1;
  logic      cond_w;
  always_comb begin
    unique case (op_w)
      OP_BC:       cond_w = psw_q[PSW_CY];
      OP_BNC:      cond_w = ~psw_q[PSW_CY];
      OP_BZ:       cond_w = psw_q[PSW_Z];
      OP_BNZ:      cond_w = ~psw_q[PSW_Z];
      OP_BT_SADDR: cond_w = bit_m;
      OP_BT_SFR:   cond_w = bit_s;
      OP_BT_ACC:   cond_w = bit_a;
      OP_BT_PSW:   cond_w = bit_p;
      OP_BF_SADDR: cond_w = ~bit_m;
      OP_BF_SFR:   cond_w = ~bit_s;
      OP_BF_ACC:   cond_w = ~bit_a;
      OP_BF_PSW:   cond_w = ~bit_p;
      OP_DECREMENT_AND_LOOP_BRANCH_B, OP_DECREMENT_AND_LOOP_BRANCH_C, OP_DECREMENT_AND_LOOP_BRANCH_MEM:
                   cond_w = (dec_w != 8'h0);
      default:     cond_w = 1'b0;
    endcase
  end

  // Branch target from the offset, sign-extended
  logic [7:0] disp_q;
  wire [15:0] sext_w   = {{8{disp_q[7]}}, disp_q};
  wire [15:0] target_w = pc_q + {13'h0, op_len(op_q)} + (taken_q ? sext_w : 16'h0);
  // Settle count for the selected resonator
  wire [STAB_W-1:0] stab_load = ctrl_q[CTRL_XTAL] ? STAB_W'(XTL_CYCLES - 1) :
                                                    STAB_W'(CER_CYCLES - 1);

  // Next state; a pending wake never cancels a standby entered this cycle
  always_comb begin
    state_d = state_q;
    stab_d  = stab_q;
    unique case (state_q)
      ST_STAB: begin
        if (stab_q == '0) begin
          state_d = ST_IDLE;
        end else begin
          stab_d = stab_q - STAB_W'(1);
        end
      end
      ST_IDLE: begin
        if (go_w) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (fin_w) begin
          state_d = (op_q == OP_HALT) ? ST_HALT :
                    (op_q == OP_STOP) ? ST_STOP : ST_IDLE;
        end
      end
      ST_HALT: begin
        if (wake_q) begin
          state_d = ST_IDLE;
        end
      end
      ST_STOP: begin
        if (wake_q) begin
          state_d = ST_STAB;
          stab_d  = stab_load;
        end
      end
      default: begin
        state_d = ST_STAB;
        stab_d  = stab_load;
      end
    endcase
  end

  // Architectural updates from bus writes and at the end of an instruction
  always_comb begin
    pc_d   = pc_q;
    regs_d = regs_q;
    psw_d  = psw_q;
    if (wr_ok & hit_pc) begin
      pc_d = pwdata[15:0];
    end
    if (wr_ok & hit_rg) begin
      regs_d = pwdata;
    end
    if (wr_ok & hit_psw) begin
      psw_d = pwdata[7:0];
    end
    if (fin_w) begin
      pc_d = target_w;
      unique case (op_q)
        OP_DECREMENT_AND_LOOP_BRANCH_B:   regs_d[RG_B +: 8] = dec_q;
        OP_DECREMENT_AND_LOOP_BRANCH_C:   regs_d[RG_C +: 8] = dec_q;
        OP_DECREMENT_AND_LOOP_BRANCH_MEM: regs_d[RG_MEM +: 8] = dec_q;
        OP_EI:       psw_d[PSW_IE] = 1'b1;
        OP_DI:       psw_d[PSW_IE] = 1'b0;
        default:     psw_d = psw_q;
      endcase
    end
  end

  // Wake pin: three stages, accepted when the last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {w1_q, w2_q, w3_q, wake_q} <= 4'h0;
    end else if (ce) begin
      w1_q <= wake_in;
      w2_q <= w1_q;
      w3_q <= w2_q;
      wake_q <= (w2_q == w3_q) ? w3_q : wake_q;
    end
  end

  // Core sequencing; divider restarts at a start so no partial CPU clock is counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_STAB;
      stab_q  <= STAB_W'(CER_CYCLES - 1);
      div_q   <= 3'h0;
      cnt_q   <= 4'h0;
    end else if (ce) begin
      state_q <= state_d;
      stab_q  <= stab_d;
      div_q   <= go_w ? 3'h1 : div_q + 3'h1;
      cnt_q   <= go_w ? 4'h0 : (busy_w & tick_w) ? cnt_q + 4'h1 : cnt_q;
    end
  end

  // Snapshot of the started instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q    <= OP_NOP;
      taken_q <= 1'b0;
      dec_q   <= 8'h0;
      disp_q  <= 8'h0;
    end else if (go_w) begin
      op_q    <= op_w;
      taken_q <= cond_w;
      dec_q   <= dec_w;
      disp_q  <= disp_w;
    end
  end

  // Software-visible registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= CTRL_RST;
      instr_q <= INSTR_RST;
      pc_q    <= PC_RST;
      regs_q  <= REGS_RST;
      psw_q   <= PSW_RST;
    end else if (ce) begin
      if (wr_ok & hit_ctl) begin
        ctrl_q <= {pwdata[3:1], 1'b0}; // Start reads back as zero
      end
      if (wr_ok & hit_ins) begin
        instr_q <= pwdata;
      end
      pc_q   <= pc_d;
      regs_q <= regs_d;
      psw_q  <= psw_d;
    end
  end

  // APB answer one cycle after setup; unmapped offsets flag an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      done_q    <= 1'b0;
      run_q     <= 1'b0;
    end else if (ce) begin
      pready_q  <= setup_w;
      prdata_q  <= setup_w ? (pwrite ? 32'h0 : rd_w) : prdata_q;
      pslverr_q <= setup_w & ~mapped;
      done_q    <= fin_w;
      run_q     <= (state_d == ST_IDLE) | (state_d == ST_EXEC);
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign int_accept = psw_q[PSW_IE];
  assign instr_done = done_q;
  assign cpu_run    = run_q;
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Helper: bus clocks spent since start, blind to the divider
  logic [6:0] tk_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk_q <= 7'h0;
    end else if (ce) begin
      tk_q <= go_w ? 7'h0 : busy_w ? tk_q + 7'h1 : tk_q;
    end
  end

  sequence s_fin(logic [4:0] op);
    ce && fin_w && op_q == op;
  endsequence

  a_carry_cond: assert property (
    ce && go_w && op_w == OP_BC |=> taken_q == $past(psw_q[PSW_CY]))
    else $error("carry branch decision wrong");
  a_bt_saddr: assert property (
    s_fin(OP_BT_SADDR) |=> pc_q == $past(pc_q) + 16'h4 + ($past(taken_q) ? $past(sext_w) : 16'h0))
    else $error("short-direct bit branch target wrong");
  a_bt_acc: assert property (
    s_fin(OP_BT_ACC) |=> pc_q == $past(pc_q) + 16'h3 + ($past(taken_q) ? $past(sext_w) : 16'h0))
    else $error("accumulator bit branch target wrong");
  a_bt_psw: assert property (
    s_fin(OP_BT_PSW) |=> pc_q == $past(pc_q) + 16'h4 + ($past(taken_q) ? $past(sext_w) : 16'h0))
    else $error("state word bit branch target wrong");
  a_bf_acc: assert property (
    ce && go_w && op_w == OP_BF_ACC |=> taken_q == !$past(a_w[bit_w]))
    else $error("bit-clear branch decision wrong");
  a_loop_b: assert property (
    s_fin(OP_DECREMENT_AND_LOOP_BRANCH_B) |=> regs_q[RG_B +: 8] == $past(dec_q) && taken_q == (dec_q != 8'h0))
    else $error("loop on B wrong");
  a_loop_mem: assert property (
    s_fin(OP_DECREMENT_AND_LOOP_BRANCH_MEM) |=> pc_q == $past(pc_q) + 16'h3 + ($past(taken_q) ? $past(sext_w) : 16'h0))
    else $error("memory loop target wrong");
  a_ei_sets: assert property (
    s_fin(OP_EI) |=> int_accept && pc_q == $past(pc_q) + 16'h3)
    else $error("interrupt allow failed");
  a_di_clears: assert property (
    s_fin(OP_DI) |=> !int_accept && pc_q == $past(pc_q) + 16'h3)
    else $error("interrupt block failed");
  a_stop_settle: assert property (
    ce && state_q == ST_STOP && wake_q |=> state_q == ST_STAB && stab_q == $past(stab_load))
    else $error("stop release skipped settle wait");
  a_tick_count: assert property (
    ce && fin_w |-> tk_q == 7'(({3'h0, op_clk(op_q)} << pcc_w) - 7'h1))
    else $error("instruction clock count wrong");
  a_halt_entry: assert property (
    s_fin(OP_HALT) |=> state_q == ST_HALT && pc_q == $past(pc_q) + 16'h1)
    else $error("halt entry wrong");

endmodule : bci_core

// ---- tb/bci_tb_prog_mem.sv ----
`timescale 1ns/1ns
// Program store handing instruction words to the bench by address
module bci_tb_prog_mem (
  // Fetch address and word
  input  wire logic [15:0] fetch_pc,
  output logic      [31:0] fetch_word
);
  import bci_pkg::*;

  // Erased places read all ones, an illegal code, never a stale word
  always_comb begin
    case (fetch_pc)
      16'h2000: fetch_word = {27'h0, OP_HALT};
      16'h2001: fetch_word = {27'h0, OP_STOP};
      default:  fetch_word = 32'hffff_ffff;
    endcase
  end
endmodule : bci_tb_prog_mem

// ---- tb/test_branch_and_control_instr_unit.sv ----
`timescale 1ns/1ns
module test_branch_and_control_instr_unit;
  import bci_pkg::*;

  // Short settle counts keep the run brief
  localparam int unsigned CER = 20;
  localparam int unsigned XTL = 40;

  typedef struct packed {
    logic [31:0] ins;
    logic [31:0] regs;
    logic [7:0]  processor_state_word;
    logic [3:0]  len;
    logic [3:0]  clk;
    logic        tk;
    logic [31:0] xregs;
    logic [7:0]  xpsw;
  } bci_tb_row_s;

  logic        pclk, presetn, ce, psel, penable, pwrite, wake_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, fetch_word;
  logic        pready, pslverr, err, int_accept, instr_done, cpu_run;
  logic [15:0] fetch_pc;
  int          n_mismatch, n_compared, cycles, k;
  time         t0;
  bci_tb_row_s rows [20];

  bci_core #(.CER_CYCLES(CER), .XTL_CYCLES(XTL)) u_bci_core (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_in(wake_in),
    .int_accept(int_accept), .instr_done(instr_done), .cpu_run(cpu_run)
  );

  bci_tb_prog_mem u_bci_tb_prog_mem (.fetch_pc(fetch_pc), .fetch_word(fetch_word));

  // Clock and hang guard
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One bus transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Count cycles to the completion pulse, then see it drop
  task automatic wait_done();
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (instr_done !== 1'b1 && k < 300);
    @(negedge pclk);
    check("done width", 0, instr_done);
    @(posedge pclk);
  endtask : wait_done

  function automatic logic [31:0] mk(input logic [4:0] op, input logic [2:0] b,
                                     input logic [7:0] d, input logic [7:0] s);
    return {s, d, 5'h0, b, 3'h0, op};
  endfunction : mk

  task automatic run(input bci_tb_row_s r, input logic [1:0] sel);
    int m;
    m = 1 << sel;
    apb(1, ADDR_PC, 32'h1000);
    apb(1, ADDR_REGS, r.regs);
    apb(1, ADDR_PSW, {24'h0, r.processor_state_word});
    apb(1, ADDR_INSTR, r.ins);
    apb(1, ADDR_CTRL, {28'h0, sel, 2'b01});
    wait_done();
    check("clocks", r.clk * m, k);
    apb(0, ADDR_PC, 0);
    check("pc", 32'h1000 + r.len + (r.tk ? {{24{r.ins[23]}}, r.ins[23:16]} : 0), rd);
    apb(0, ADDR_REGS, 0);
    check("regs", r.xregs, rd);
    apb(0, ADDR_PSW, 0);
    check("psw", {24'h0, r.xpsw}, rd);
    check("accept flag", r.xpsw[7], int_accept);
  endtask : run

  initial begin
    {psel, penable, pwrite, wake_in} = '0;
    paddr = '0;
    pwdata = '0;
    ce = 1'b1;
    presetn = 1'b0;
    fetch_pc = 16'h2000;
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    // Instruction, regs, psw, bytes, clocks, taken, expected regs and psw
    rows = '{
      '{mk(OP_NOP, 0, 8'h10, 0), 0, 0, 1, 2, 0, 0, 0},
      '{mk(OP_BC, 0, 8'hf0, 0), 0, 8'h01, 2, 6, 1, 0, 8'h01},
      '{mk(OP_BC, 0, 8'hf0, 0), 0, 8'h40, 2, 6, 0, 0, 8'h40},
      '{mk(OP_BNC, 0, 8'h10, 0), 0, 8'h40, 2, 6, 1, 0, 8'h40},
      '{mk(OP_BZ, 0, 8'h10, 0), 0, 8'h40, 2, 6, 1, 0, 8'h40},
      '{mk(OP_BNZ, 0, 8'h10, 0), 0, 8'h41, 2, 6, 0, 0, 8'h41},
      '{mk(OP_BT_SADDR, 5, 8'h10, 0), 32'h2000_0000, 0, 4, 10, 1, 32'h2000_0000, 0},
      '{mk(OP_BT_SFR, 0, 8'h7f, 8'h01), 0, 0, 4, 10, 1, 0, 0},
      '{mk(OP_BT_ACC, 7, 8'h80, 0), 32'h80, 0, 3, 8, 1, 32'h80, 0},
      '{mk(OP_BT_PSW, 6, 8'h10, 0), 0, 8'h40, 4, 10, 1, 0, 8'h40},
      '{mk(OP_BT_ACC, 6, 8'h10, 0), 32'h80, 0, 3, 8, 0, 32'h80, 0},
      '{mk(OP_BF_SADDR, 5, 8'h10, 0), 32'h2000_0000, 0, 4, 10, 0, 32'h2000_0000, 0},
      '{mk(OP_BF_SFR, 1, 8'h10, 8'h01), 0, 0, 4, 10, 1, 0, 0},
      '{mk(OP_BF_ACC, 0, 8'h10, 0), 32'h80, 0, 3, 8, 1, 32'h80, 0},
      '{mk(OP_BF_PSW, 0, 8'h10, 0), 0, 8'h40, 4, 10, 1, 0, 8'h40},
      '{mk(OP_DECREMENT_AND_LOOP_BRANCH_B, 0, 8'h10, 0), 32'h100, 0, 2, 6, 0, 0, 0},
      '{mk(OP_DECREMENT_AND_LOOP_BRANCH_C, 0, 8'h10, 0), 0, 0, 2, 6, 1, 32'h00ff_0000, 0},
      '{mk(OP_DECREMENT_AND_LOOP_BRANCH_MEM, 0, 8'h10, 0), 32'h0200_0000, 0, 3, 8, 1, 32'h0100_0000, 0},
      '{mk(OP_EI, 0, 8'h10, 0), 0, 0, 3, 6, 0, 0, 8'h80},
      '{mk(OP_DI, 0, 8'h10, 0), 0, 8'h81, 3, 6, 0, 0, 8'h01}
    };
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t0 = $time;
    @(posedge pclk);
    // Reset values, unmapped place, settle time
    check("run in settle", 0, cpu_run);
    apb(0, ADDR_PC, 0);
    check("pc reset", {16'h0, PC_RST}, rd);
    apb(0, ADDR_REGS, 0);
    check("regs reset", REGS_RST, rd);
    apb(0, ADDR_PSW, 0);
    check("psw reset", {24'h0, PSW_RST}, rd);
    apb(0, 8'h18, 0);
    check("unmapped err", 1, err);
    check("unmapped data", 0, rd);
    while (cpu_run !== 1'b1 && $time - t0 < 400) @(posedge pclk);
    check("settle", 1, ($time - t0) / 4 >= CER && ($time - t0) / 4 <= CER + 3);
    // Table of ordinary cases, CPU clock select cycling 0..3
    for (int i = 0; i < 20; i++) begin
      run(rows[i], i[1:0]);
    end
    // Writes and a second start during execution are dropped
    apb(1, ADDR_PC, 32'h1000);
    apb(1, ADDR_REGS, 32'h2000_0000);
    apb(1, ADDR_INSTR, mk(OP_BT_SADDR, 5, 8'h10, 0));
    apb(1, ADDR_CTRL, 32'h0000_000d);
    apb(1, ADDR_PC, 32'h0500);
    apb(0, ADDR_STATUS, 0);
    check("busy", 1, rd[0]);
    apb(1, ADDR_CTRL, 32'h1);
    wait_done();
    apb(0, ADDR_PC, 0);
    check("pc after busy", 32'h1014, rd);
    // Standby instructions fetched from the program store
    apb(1, ADDR_PC, 32'h2000);
    apb(1, ADDR_INSTR, fetch_word);
    apb(1, ADDR_CTRL, 32'h1);
    wait_done();
    check("halt clocks", 1, k >= 2 && k <= 3);
    apb(0, ADDR_STATUS, 0);
    check("halted", 1, rd[2]);
    check("run in halt", 0, cpu_run);
    apb(0, ADDR_PC, 0);
    check("pc after halt", 32'h2001, rd);
    fetch_pc = rd[15:0];
    wake_in <= 1'b1;
    k = 0;
    while (cpu_run !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    check("halt wake", 1, k <= 8);
    wake_in <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1, ADDR_INSTR, fetch_word);
    apb(1, ADDR_CTRL, 32'h3);
    wait_done();
    apb(0, ADDR_STATUS, 0);
    check("stopped", 1, rd[3]);
    wake_in <= 1'b1;
    t0 = $time;
    repeat (6) @(posedge pclk);
    wake_in <= 1'b0;
    while (cpu_run !== 1'b1 && $time - t0 < 800) @(posedge pclk);
    check("crystal settle", 1, ($time - t0) / 4 >= XTL && ($time - t0) / 4 <= XTL + 8);
    apb(0, ADDR_PC, 0);
    check("pc after stop", 32'h2002, rd);
    // Reset in mid-run clears the state word and settles on the ceramic count again
    apb(1, ADDR_PSW, 32'h80);
    check("accept before reset", 1, int_accept);
    presetn <= 1'b0;
    @(posedge pclk);
    check("accept in reset", 0, int_accept);
    presetn <= 1'b1;
    t0 = $time;
    @(posedge pclk);
    check("run after reset", 0, cpu_run);
    while (cpu_run !== 1'b1 && $time - t0 < 400) @(posedge pclk);
    check("settle again", 1, ($time - t0) / 4 >= CER && ($time - t0) / 4 <= CER + 3);
    apb(0, ADDR_PC, 0);
    check("pc after reset", {16'h0, PC_RST}, rd);
    wrap_up();
  end
endmodule : test_branch_and_control_instr_unit
